// ==== design/instr_decode_regs.vh ====
`ifndef INSTR_DECODE_REGS_VH
`define INSTR_DECODE_REGS_VH
`define IW_WIDTH 14
`define IW_TOP_MSB 13
`define IW_TOP_LSB 12
`define IW_OP_MSB 11
`define IW_OP_LSB 8
`define IW_DEST_BIT 7
`define IW_FILE_MSB 6
`define IW_FILE_LSB 0
`define IW_BIT_MSB 9
`define IW_BIT_LSB 7
`define IW_K8_MSB 7
`define IW_K11_MSB 10
`define TOP_BYTE 2'h0
`define TOP_BIT 2'h1
`define TOP_JUMP 2'h2
`define TOP_LIT 2'h3
`define GRP_BYTE 2'h0
`define GRP_BIT 2'h1
`define GRP_LITCTL 2'h2
`define OSC_PER_CYCLE 4
`define PHASE_LAST 2'h3
`define BIT_SKIP_CLR 2'h2
`define BIT_SKIP_SET 2'h3
`define CTL_RETURN 8'h08
`define CTL_RETFIE 8'h09
`define CTL_SLEEP 8'h63
`define CTL_CLRWDT 8'h64
`define OP_RETLW_MSB 3'h5
`endif

// ==== design/cycle_phase_counter.v ====
`timescale 1ns/1ps
`include "instr_decode_regs.vh"
module cycle_phase_counter #(
    parameter PERIODS = `OSC_PER_CYCLE
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // phase
    output reg [1:0] phase,
    output wire cycle_end
);
    // RL10
    assign cycle_end = (phase == PERIODS - 1);
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase <= 2'h0;
        end else if (cycle_end) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
endmodule // cycle_phase_counter

// ==== design/instr_word_format_decoder.v ====
`timescale 1ns/1ps
`include "instr_decode_regs.vh"

// Overview of operation
// RL1: each instruction is one 14-bit word holding an opcode and operand fields.
// RL2: every word falls into exactly one group: byte, bit, or literal and control.
// RL3: byte ops send the result to the accumulator when d is 0, to the file register when d is 1.
// RL4: the file operand address is the 7-bit field spanning 0x00 to 0x7F.
// RL5: bit ops pick one of the 8 bits of the addressed register with the bit select field.
// RL6: literal and control ops carry an 8-bit or 11-bit immediate depending on the opcode.
// RL7: don't-care positions in an encoding do not change behaviour.
// RL8: an instruction takes one instruction cycle unless a test is true or the PC changes.
// RL9: a true test or PC change costs a second cycle run as a no_operation.
// RL10: one instruction cycle is four oscillator periods.
// RL11: read-modify-write of an I/O register takes the pin levels as source.
// RL12: bit test and skip is top bits 01 with 11 for skip-if-set; one cycle, two if skipped.
// RL13: group, fields and destination are presented together, and a following word is squashed on a no_operation cycle.
module instr_word_format_decoder #(
    parameter WORD_W = `IW_WIDTH
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // fetch side
    input wire [WORD_W-1:0] instr_word,
    output wire fetch_strobe,
    // datapath feedback: test_true sampled at end of the cycle, I/O inputs on every clock
    input wire test_true,
    input wire [7:0] io_pin_levels,
    input wire [7:0] io_latch,
    input wire io_select,
    // decoded outputs
    output reg [1:0] group,
    output reg [6:0] file_addr,
    output reg dest_file,
    output reg dest_acc,
    output reg [2:0] bit_sel,
    output reg [7:0] bit_mask,
    output reg [10:0] literal,
    output reg literal_wide,
    output reg is_skip_test,
    output reg skip_on_set,
    output reg pc_change,
    output reg no_operation,
    output reg [7:0] rmw_source,
    output wire cycle_end
);
    // opcode values inside each encoding space
    localparam [3:0] OP_DEC_SKIP = 4'hB;
    localparam [3:0] OP_INC_SKIP = 4'hF;
    localparam [3:0] OP_CTL = 4'h0;
    localparam [1:0] OP_RET_LIT = 2'h1;
    localparam [1:0] PHASE_FIRST = 2'h0;

    wire [1:0] phase;
    wire [7:0] next_bit_mask;
    reg [WORD_W-1:0] word;
    reg squash;
    reg next_squash;
    reg branch_taken;
    reg [1:0] top;
    reg [3:0] op;
    reg [7:0] low;
    reg dest_bit;
    reg is_byte_space;
    reg is_bit_space;
    reg is_ctl_space;
    reg [1:0] next_group;
    reg [6:0] next_file_addr;
    reg next_dest_file;
    reg next_dest_acc;
    reg [2:0] next_bit_sel;
    reg [10:0] next_literal;
    reg next_literal_wide;
    reg next_pc_change;
    reg next_skip_test;
    reg next_skip_on_set;
    reg next_no_operation;
    reg [7:0] next_rmw_source;

    cycle_phase_counter #(
        .PERIODS(`OSC_PER_CYCLE)
    ) u_phase (
        .sys_clk(sys_clk),
        .rst(rst),
        .phase(phase),
        .cycle_end(cycle_end)
    );

    // one fetch per instruction cycle
    assign fetch_strobe = cycle_end; // RL10

    // a squashed slot never squashes again, so one taken branch costs one extra cycle
    always @* begin
        branch_taken = pc_change || (is_skip_test && test_true);
        next_squash = squash;
        if (cycle_end) begin
            if (squash) begin
                next_squash = 1'b0;
            end else begin
                next_squash = branch_taken; // RL8 RL9 RL13
            end
        end
    end

    // latch the word at the cycle boundary
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            word <= {WORD_W{1'b0}};
            squash <= 1'b0;
        end else begin
            squash <= next_squash;
            if (cycle_end) begin
                word <= instr_word; // RL1
            end
        end
    end

    always @* begin
        top = word[`IW_TOP_MSB:`IW_TOP_LSB];
        op = word[`IW_OP_MSB:`IW_OP_LSB];
        low = word[7:0];
        dest_bit = word[`IW_DEST_BIT];
        is_byte_space = (top == `TOP_BYTE);
        is_bit_space = (top == `TOP_BIT);
        // opcode 0 with d clear holds the control words, not byte ops
        is_ctl_space = is_byte_space && (op == OP_CTL) && !dest_bit;
    end

    // branch and skip timing per encoding space
    always @* begin
        next_pc_change = 1'b0;
        next_skip_test = 1'b0;
        case (top)
            `TOP_JUMP: begin
                // call and goto always reload the program counter
                next_pc_change = 1'b1; // RL8
            end
            `TOP_LIT: begin
                // return-with-literal; low two opcode bits are don't-care
                if (op[3:2] == OP_RET_LIT) begin
                    next_pc_change = 1'b1; // RL7
                end
            end
            `TOP_BIT: begin
                if (op[3:2] == `BIT_SKIP_CLR) begin
                    next_skip_test = 1'b1; // RL12
                end
                if (op[3:2] == `BIT_SKIP_SET) begin
                    next_skip_test = 1'b1; // RL12
                end
            end
            `TOP_BYTE: begin
                // decrement/increment and skip if zero
                if (op == OP_DEC_SKIP) begin
                    next_skip_test = 1'b1;
                end
                if (op == OP_INC_SKIP) begin
                    next_skip_test = 1'b1;
                end
                if (is_ctl_space && (low == `CTL_RETURN)) begin
                    next_pc_change = 1'b1;
                end
                if (is_ctl_space && (low == `CTL_RETFIE)) begin
                    next_pc_change = 1'b1;
                end
            end
            default: begin
                next_pc_change = 1'b0;
            end
        endcase
    end

    always @* begin
        case (top)
            `TOP_BYTE: begin
                if (is_ctl_space) begin
                    next_group = `GRP_LITCTL; // RL2
                end else begin
                    next_group = `GRP_BYTE; // RL2
                end
            end
            `TOP_BIT: begin
                next_group = `GRP_BIT; // RL2
            end
            `TOP_JUMP: begin
                next_group = `GRP_LITCTL; // RL2
            end
            `TOP_LIT: begin
                next_group = `GRP_LITCTL; // RL2
            end
            default: begin
                next_group = `GRP_LITCTL;
            end
        endcase
    end

    // file and bit fields pass through whatever the group
    always @* begin
        next_file_addr = word[`IW_FILE_MSB:`IW_FILE_LSB]; // RL4
        next_bit_sel = word[`IW_BIT_MSB:`IW_BIT_LSB]; // RL5
        next_dest_file = 1'b0;
        next_dest_acc = 1'b0;
        if (is_byte_space && !is_ctl_space) begin
            next_dest_file = dest_bit; // RL3
            next_dest_acc = !dest_bit; // RL3
        end
    end

    // jumps carry 11 bits; every other word the low byte, zero-extended
    always @* begin
        if (top == `TOP_JUMP) begin
            next_literal = word[`IW_K11_MSB:0]; // RL6
            next_literal_wide = 1'b1;
        end else begin
            next_literal = {3'h0, word[`IW_K8_MSB:0]}; // RL6
            next_literal_wide = 1'b0;
        end
    end

    always @* begin
        next_skip_on_set = is_bit_space && (op[3:2] == `BIT_SKIP_SET); // RL12
        // plain nop: bits 6:5 of the low byte are don't-care
        next_no_operation = is_ctl_space && (word[4:0] == 5'h00); // RL7
    end

    // one compare per mask bit, no shifter
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1) begin : g_mask
            assign next_bit_mask[bit_idx] = (word[`IW_BIT_MSB:`IW_BIT_LSB] == bit_idx); // RL5
        end
    endgenerate

    // pins, not latch, when io_select is set: the latch would hide a pin pulled low from outside
    always @* begin
        if (io_select) begin
            next_rmw_source = io_pin_levels; // RL11
        end else begin
            next_rmw_source = io_latch;
        end
    end

    // all fields registered together so they line up in one cycle
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            group <= `GRP_LITCTL;
            file_addr <= 7'h00;
            dest_file <= 1'b0;
            dest_acc <= 1'b0;
            bit_sel <= 3'h0;
            bit_mask <= 8'h00;
            literal <= 11'h000;
            literal_wide <= 1'b0;
            is_skip_test <= 1'b0;
            skip_on_set <= 1'b0;
            pc_change <= 1'b0;
            no_operation <= 1'b1;
        end else if (phase == PHASE_FIRST) begin
            if (squash) begin
                // forced no_operation; fields cleared so nothing is written
                group <= `GRP_LITCTL; // RL9 RL13
                file_addr <= 7'h00;
                dest_file <= 1'b0;
                dest_acc <= 1'b0;
                bit_sel <= 3'h0;
                bit_mask <= 8'h00;
                literal <= 11'h000;
                literal_wide <= 1'b0;
                is_skip_test <= 1'b0;
                skip_on_set <= 1'b0;
                pc_change <= 1'b0;
                no_operation <= 1'b1; // RL9
            end else begin
                group <= next_group; // RL2 RL13
                file_addr <= next_file_addr;
                dest_file <= next_dest_file;
                dest_acc <= next_dest_acc;
                bit_sel <= next_bit_sel;
                bit_mask <= next_bit_mask;
                literal <= next_literal;
                literal_wide <= next_literal_wide;
                is_skip_test <= next_skip_test;
                skip_on_set <= next_skip_on_set;
                pc_change <= next_pc_change;
                no_operation <= next_no_operation;
            end
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rmw_source <= 8'h00;
        end else begin
            rmw_source <= next_rmw_source; // RL11
        end
    end
endmodule // instr_word_format_decoder

// ==== verif/instr_word_format_decoder_sva.sv ====
`timescale 1ns/1ps
`include "instr_decode_regs.vh"
module instr_word_format_decoder_sva #(
    parameter WORD_W = 14
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // design ports
    input wire [WORD_W-1:0] instr_word,
    input wire fetch_strobe,
    input wire test_true,
    input wire [7:0] io_pin_levels,
    input wire [7:0] io_latch,
    input wire io_select,
    input wire [1:0] group,
    input wire [6:0] file_addr,
    input wire dest_file,
    input wire dest_acc,
    input wire [2:0] bit_sel,
    input wire [7:0] bit_mask,
    input wire [10:0] literal,
    input wire literal_wide,
    input wire is_skip_test,
    input wire pc_change,
    input wire no_operation,
    input wire [7:0] rmw_source,
    input wire cycle_end
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_skip_taken;
        cycle_end && is_skip_test && test_true;
    endsequence
    sequence s_jump;
        cycle_end && pc_change;
    endsequence
    a_cycle_period: assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end) else $error("cycle not 4 clocks");
    a_strobe_cycle: assert property (fetch_strobe == cycle_end) else $error("strobe off cycle end");
    a_fields_stand: assert property ($changed({group, file_addr, literal}) |=>
        $stable({group, file_addr, literal}) [*3]) else $error("fields not held");
    a_group_legal: assert property (group != 2'h3) else $error("no such group");
    a_dest_select: assert property (group == `GRP_BYTE && !no_operation |-> dest_acc == !dest_file)
        else $error("destination wrong");
    a_bit_mask: assert property (group == `GRP_BIT && !no_operation |-> bit_mask == (8'h01 << bit_sel))
        else $error("bit mask wrong");
    a_narrow_literal: assert property (group == `GRP_LITCTL && !literal_wide |-> literal[10:8] == 3'h0)
        else $error("short literal wide");
    a_file_field: assert property (cycle_end |-> ##3 (no_operation || group == `GRP_LITCTL ||
        file_addr == $past(instr_word[6:0], 3))) else $error("file address wrong");
    a_squash_next: assert property (s_skip_taken or s_jump |-> ##[1:4] no_operation)
        else $error("no squash");
    a_single_cycle: assert property (cycle_end && !pc_change && !(is_skip_test && test_true) && !no_operation
        |-> ##3 !no_operation) else $error("stray squash");
    a_rmw_pins: assert property (1'b1 |=> rmw_source == ($past(io_select) ? $past(io_pin_levels) :
        $past(io_latch))) else $error("rmw source wrong");
endmodule // instr_word_format_decoder_sva
bind instr_word_format_decoder instr_word_format_decoder_sva #(.WORD_W(WORD_W)) sva_u (.*);

// ==== verif/prog_mem_model.sv ====
`timescale 1ns/1ps
module prog_mem_model (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // fetch side
    input wire cycle_end,
    output logic [13:0] instr_word
);
    // spare slots hold a literal load so no stray jump fires
    logic [13:0] rom [32] = '{default: 14'h3000};
    logic [4:0] addr;
    assign instr_word = rom[addr];
    always @(posedge sys_clk or posedge rst) begin
        if (rst) addr <= 5'h00;
        else if (cycle_end) addr <= addr + 5'h01;
    end
endmodule // prog_mem_model

// ==== verif/instr_word_format_decoder_tb.sv ====
`timescale 1ns/1ps
`include "instr_decode_regs.vh"
module instr_word_format_decoder_tb;
    logic sys_clk = 0, rst = 1, test_true = 0, io_select = 0;
    logic [7:0] io_pin_levels = 8'h3C, io_latch = 8'hC3, bit_mask, rmw_source;
    logic [13:0] instr_word;
    logic fetch_strobe, dest_file, dest_acc, literal_wide, is_skip_test, skip_on_set, pc_change, no_operation, cycle_end;
    logic [1:0] group;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    logic [10:0] literal;
    int err_total = 0, num_checks = 0, cyc = 0;
    // word, group, pc change, test result, squashed
    logic [18:0] rows [17] = '{{14'h07FF, 2'h0, 3'h0}, {14'h0300, 2'h0, 3'h0}, {14'h17D5, 2'h1, 3'h0},
        {14'h1D12, 2'h1, 3'h2}, {14'h2FFF, 2'h2, 3'h1}, {14'h33A5, 2'h2, 3'h0}, {14'h30A5, 2'h2, 3'h0},
        {14'h22AA, 2'h2, 3'h4}, {14'h07FF, 2'h0, 3'h1}, {14'h1801, 2'h1, 3'h0}, {14'h3EFF, 2'h2, 3'h0},
        {14'h0008, 2'h2, 3'h4}, {14'h3000, 2'h2, 3'h1}, {14'h0BFF, 2'h0, 3'h2}, {14'h3000, 2'h2, 3'h1},
        {14'h37AA, 2'h2, 3'h4}, {14'h3000, 2'h2, 3'h1}};
    instr_word_format_decoder dut_u (.*);
    prog_mem_model mem_u (.*);
    always #4 sys_clk = ~sys_clk;
    task chk(string n, logic [10:0] e, logic [10:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task end_of_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // tests need about 75 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 300) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        logic [18:0] r;
        logic [13:0] w;
        for (int i = 0; i < 17; i++) mem_u.rom[i] = rows[i][18:5];
        @(negedge sys_clk);
        chk("reset group", `GRP_LITCTL, group);
        chk("reset squash", 1, no_operation);
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        for (int k = 0; k < 18; k++) begin
            do @(negedge sys_clk); while (cycle_end !== 1'b1);
            if (k > 0) begin
                r = rows[k-1];
                w = r[18:5];
                chk("no_operation", r[0], no_operation);
                chk("fetch_strobe", 1, fetch_strobe);
                chk("rmw_source", io_select ? 8'h3C : 8'hC3, rmw_source);
                if (!r[0]) begin
                    chk("group", r[4:3], group);
                    chk("pc_change", r[2], pc_change);
                    if (r[4:3] != `GRP_LITCTL) chk("file_addr", w[6:0], file_addr);
                    if (r[4:3] == `GRP_BYTE) chk("dest_file", w[7], dest_file);
                    if (r[4:3] == `GRP_BYTE) chk("dest_acc", !w[7], dest_acc);
                    if (r[4:3] == `GRP_BYTE) chk("byte skip", w[11:8] == 4'hB || w[11:8] == 4'hF, is_skip_test);
                    if (r[4:3] == `GRP_BIT) chk("bit_mask", 8'h01 << w[9:7], bit_mask);
                    if (r[4:3] == `GRP_BIT) chk("skip_on_set", w[11] & w[10], skip_on_set);
                    chk("literal_wide", w[13:12] == 2'h2, literal_wide);
                    if (r[4:3] == `GRP_BIT) chk("bit_sel", w[9:7], bit_sel);
                    if (r[4:3] == `GRP_BIT) chk("skip", w[11], is_skip_test);
                    if (r[4:3] == `GRP_LITCTL) chk("literal", w[13:12] == 2'h2 ? w[10:0] : w[7:0], literal);
                end
            end
            @(posedge sys_clk);
            if (k < 17) test_true <= rows[k][1];
            io_select <= ~io_select;
        end
        end_of_test();
    end
endmodule // instr_word_format_decoder_tb
